// ===== irq_prio_ctrl.sv
`timescale 1ns/100ps
module irq_prio_ctrl
  import irq_prio_pkg::*;
#(
  parameter int VECTOR_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rstn_i,
  // Register port
  input  wire logic [7:0]              addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [7:0]              rdata_o,
  // External interrupt pins, asynchronous
  input  wire logic [6:0]              ext_irq_input_i,
  // Peripheral flags, same clock
  input  wire logic                    timer_a_overflow_i,
  input  wire logic                    timer_b_overflow_i,
  input  wire logic                    serial_a_rx_flag_i,
  input  wire logic                    serial_a_tx_flag_i,
  input  wire logic                    serial_b_rx_flag_i,
  input  wire logic                    serial_b_tx_flag_i,
  // CPU core sequencer
  input  wire logic                    cpu_ack_i,
  input  wire logic                    cpu_reti_i,
  output cpu_req_s                     cpu_req_o,
  output logic      [VECTOR_WIDTH-1:0] irq_vector_o,
  output logic      [3:0]              peri_ack_o,
  // Power control
  output logic                         stop_o,
  output logic                         idle_o,
  output logic                         baud_double_o,
  output logic                         watchdog_start_o,
  output logic                         wake_o,
  // Summary interrupt line of the enabled external flags
  output logic                         irq_o
);

  // Vector table entries are 16 bits; narrower than a byte is useless
  if (VECTOR_WIDTH < 8 || VECTOR_WIDTH > 16) begin : g_width_check
    $error("VECTOR_WIDTH must lie between 8 and 16");
  end

  // Reset release through two flops
  logic       rst_meta;
  logic       rst_n;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Registers and state
  logic [7:0]     power_control;
  logic [7:0]     priority_low_bits;
  logic [7:0]     priority_high_bits;
  logic [7:0]     ext_enable;
  logic [7:0]     peri_enable;
  logic [7:0]     trigger_ctrl;
  logic [6:0]     ext_flag;
  logic [3:0]     in_service;
  logic [6:0]     pin_s1;
  logic [6:0]     pin_s2;
  logic [6:0]     pin_s3;
  logic [6:0]     pin_level;
  logic [6:0]     pin_prev;
  cpu_req_s       cpu_req;

  // Register write decode
  wire wr_power   = wr_i && (addr_i == POWER_CONTROL_ADDR);
  wire wr_low     = wr_i && (addr_i == PRIO_LOW_ADDR);
  wire wr_high    = wr_i && (addr_i == PRIO_HIGH_ADDR);
  wire wr_ext_en  = wr_i && (addr_i == ENABLE_EXT_ADDR);
  wire wr_peri_en = wr_i && (addr_i == ENABLE_PERI_ADDR);
  wire wr_trigger = wr_i && (addr_i == TRIGGER_CTRL_ADDR);
  wire wr_flag    = wr_i && (addr_i == EXT_FLAG_ADDR);

  // Pin filter: a change counts only once stages two and three agree
  // The first stage may go metastable, so only stages two and three feed the filter
  wire [6:0] next_pin_level = (pin_s2 & pin_s3) | (pin_level & (pin_s2 ^ pin_s3));
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1    <= EXT_PIN_RST;
      pin_s2    <= EXT_PIN_RST;
      pin_s3    <= EXT_PIN_RST;
      pin_level <= EXT_PIN_RST;
      pin_prev  <= EXT_PIN_RST;
    end else begin
      pin_s1    <= ext_irq_input_i;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= next_pin_level;
      pin_prev  <= pin_level;
    end
  end

  // Edge detection on the filtered levels
  wire [6:0] pin_fall = pin_prev & ~pin_level;
  wire [6:0] pin_rise = ~pin_prev & pin_level;

  // Flag set events; 2 and 3 have selectable polarity, 4-6 are rising edge
  // Level mode re-arms its flag every cycle the pin stays low, even under a clear
  wire [6:0] ext_set;
  assign ext_set[0]   = trigger_ctrl[0] ? pin_fall[0] : ~pin_level[0];
  assign ext_set[1]   = trigger_ctrl[1] ? pin_fall[1] : ~pin_level[1];
  assign ext_set[2]   = trigger_ctrl[2] ? pin_rise[2] : pin_fall[2];
  assign ext_set[3]   = trigger_ctrl[3] ? pin_rise[3] : pin_fall[3];
  assign ext_set[6:4] = pin_rise[6:4];

  // Source taken by the core this cycle, one-hot by polling position
  wire                   ack_take = cpu_ack_i && cpu_req.valid;
  wire [NUM_SRC-1:0]     ack_hot  = ack_take ? (NUM_SRC'(1) << cpu_req.source) : '0;

  // Flags clear when the core takes them or on a write of one
  wire [6:0] ext_ack = {ack_hot[P_EXT6], ack_hot[P_EXT5], ack_hot[P_EXT4], ack_hot[P_EXT3],
                        ack_hot[P_EXT2], ack_hot[P_EXT1], ack_hot[P_EXT0]};
  wire [6:0] ext_clr = ext_ack | (wr_flag ? wdata_i[6:0] : 7'h00);
  // A new event in the clearing cycle survives
  wire [6:0] next_ext_flag = (ext_flag & ~ext_clr) | ext_set;

  // Pending requests gated by their enables, in polling order
  wire global_en = ext_enable[GLOBAL_EN_BIT];
  wire [NUM_SRC-1:0] pend;
  assign pend[P_EXT0]  = ext_flag[0] & ext_enable[0];
  assign pend[P_EXT1]  = ext_flag[1] & ext_enable[1];
  assign pend[P_EXT2]  = ext_flag[2] & ext_enable[2];
  assign pend[P_EXT3]  = ext_flag[3] & ext_enable[3];
  assign pend[P_EXT4]  = ext_flag[4] & ext_enable[4];
  assign pend[P_EXT5]  = ext_flag[5] & ext_enable[5];
  assign pend[P_EXT6]  = ext_flag[6] & ext_enable[6];
  assign pend[P_TIM_A] = timer_a_overflow_i & peri_enable[0];
  assign pend[P_TIM_B] = timer_b_overflow_i & peri_enable[1];
  assign pend[P_SER_A] = (serial_a_rx_flag_i | serial_a_tx_flag_i) & peri_enable[2];
  assign pend[P_SER_B] = (serial_b_rx_flag_i | serial_b_tx_flag_i) & peri_enable[3];

  // Winner: highest level, earliest polling position on a tie
  // Only a strictly higher level replaces the candidate, so scan order is polling order
  logic       best_found;
  logic [1:0] best_lvl;
  src_idx_t   best_src;
  always_comb begin
    logic [1:0] lvl;
    best_found = 1'b0;
    best_lvl   = 2'b00;
    best_src   = '0;
    lvl        = 2'b00;
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl = {priority_high_bits[SRC_GROUP[i]], priority_low_bits[SRC_GROUP[i]]};
      if (pend[i] && (!best_found || lvl > best_lvl)) begin
        best_found = 1'b1;
        best_lvl   = lvl;
        best_src   = src_idx_t'(i);
      end
    end
  end

  // Highest level now in service
  // A return retires the top active level, which suits a core that nests strictly by level
  wire       serving   = |in_service;
  wire [1:0] serve_lvl = in_service[3] ? 2'd3 : in_service[2] ? 2'd2 : in_service[1] ? 2'd1 : 2'd0;
  wire       preempt   = !serving || (best_lvl > serve_lvl);

  // Request to the core; dropped in the ack cycle so a taken one never repeats
  // Registering costs a cycle of latency but keeps level and vector aligned with valid
  cpu_req_s next_cpu_req;
  assign next_cpu_req.valid  = best_found && global_en && preempt && !cpu_ack_i;
  assign next_cpu_req.level  = best_lvl;
  assign next_cpu_req.source = best_src;
  wire [15:0] next_vector = next_cpu_req.valid ? SRC_VECTOR[best_src] : RESET_VECTOR;

  // Return clears the top level first, then a take marks its own level
  wire [3:0] reti_clr       = (cpu_reti_i && serving) ? (4'h1 << serve_lvl) : 4'h0;
  wire [3:0] take_set       = ack_take ? (4'h1 << cpu_req.level) : 4'h0;
  wire [3:0] next_in_service = (in_service & ~reti_clr) | take_set;

  // Taken timer and serial sources, so the peripherals can drop their flags
  wire [3:0] next_peri_ack = {ack_hot[P_SER_B], ack_hot[P_SER_A], ack_hot[P_TIM_B], ack_hot[P_TIM_A]};

  // Wake from stop needs only the enabled input 0 event; it wins over a write
  // Limitation: this path runs on the block clock, so stop must not gate that clock
  wire wake_event = ext_set[0] && ext_enable[0] && power_control[PC_STOP_BIT];
  wire idle_exit  = next_cpu_req.valid && power_control[PC_IDLE_BIT];
  wire [7:0] power_written = wr_power ? (wdata_i & POWER_CONTROL_MASK) : power_control;
  wire [7:0] next_power_control = power_written & ~{6'h00, wake_event, idle_exit};

  // Control registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_control      <= POWER_CONTROL_RST;
      priority_low_bits  <= PRIO_LOW_RST;
      priority_high_bits <= PRIO_HIGH_RST;
      ext_enable         <= ENABLE_EXT_RST;
      peri_enable        <= ENABLE_PERI_RST;
      trigger_ctrl       <= TRIGGER_CTRL_RST;
    end else begin
      power_control <= next_power_control;
      if (wr_low) begin
        priority_low_bits <= wdata_i & PRIO_LOW_MASK;
      end
      if (wr_high) begin
        priority_high_bits <= wdata_i & PRIO_HIGH_MASK;
      end
      if (wr_ext_en) begin
        ext_enable <= wdata_i;
      end
      if (wr_peri_en) begin
        peri_enable <= wdata_i & ENABLE_PERI_MASK;
      end
      if (wr_trigger) begin
        trigger_ctrl <= wdata_i & TRIGGER_CTRL_MASK;
      end
    end
  end

  // Flags, service state and core-facing outputs
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_flag     <= '0;
      in_service   <= '0;
      cpu_req      <= '0;
      irq_vector_o <= '0;
      peri_ack_o   <= '0;
      wake_o       <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      ext_flag     <= next_ext_flag;
      in_service   <= next_in_service;
      cpu_req      <= next_cpu_req;
      irq_vector_o <= next_vector[VECTOR_WIDTH-1:0];
      peri_ack_o   <= next_peri_ack;
      wake_o       <= wake_event;
      irq_o        <= |(next_ext_flag & ext_enable[6:0]);
    end
  end

  // Read data selection; reserved bits and unmapped offsets read zero
  logic [7:0] read_sel;
  always_comb begin
    unique case (addr_i)
      POWER_CONTROL_ADDR: read_sel = power_control;
      PRIO_LOW_ADDR:      read_sel = priority_low_bits;
      PRIO_HIGH_ADDR:     read_sel = priority_high_bits;
      ENABLE_EXT_ADDR:    read_sel = ext_enable;
      ENABLE_PERI_ADDR:   read_sel = peri_enable;
      TRIGGER_CTRL_ADDR:  read_sel = trigger_ctrl;
      EXT_FLAG_ADDR:      read_sel = {1'b0, ext_flag};
      SERVICE_ADDR:       read_sel = {4'h0, in_service};
      default:            read_sel = 8'h00;
    endcase
  end

  // Read data stand for the one cycle after the strobe only
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? read_sel : 8'h00;
    end
  end

  // Power and watchdog bits leave straight from their flops
  assign cpu_req_o        = cpu_req;
  assign stop_o           = power_control[PC_STOP_BIT];
  assign idle_o           = power_control[PC_IDLE_BIT];
  assign baud_double_o    = power_control[PC_BAUD_BIT];
  assign watchdog_start_o = priority_low_bits[PL_WATCHDOG_BIT];

endmodule // irq_prio_ctrl

// ===== irq_prio_pkg.sv
package irq_prio_pkg;

  // Number of request sources and index type, in polling order
  localparam int NUM_SRC = 11;
  typedef logic [3:0] src_idx_t;

  // Register offsets
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] PRIO_LOW_ADDR      = 8'ha9;
  localparam logic [7:0] PRIO_HIGH_ADDR     = 8'hb9;
  localparam logic [7:0] ENABLE_EXT_ADDR    = 8'he8;
  localparam logic [7:0] ENABLE_PERI_ADDR   = 8'he9;
  localparam logic [7:0] TRIGGER_CTRL_ADDR  = 8'hea;
  localparam logic [7:0] EXT_FLAG_ADDR      = 8'heb;
  localparam logic [7:0] SERVICE_ADDR       = 8'hec;

  // Values after reset
  localparam logic [7:0] POWER_CONTROL_RST  = 8'h00;
  localparam logic [7:0] PRIO_LOW_RST       = 8'h00;
  localparam logic [7:0] PRIO_HIGH_RST      = 8'h00;
  localparam logic [7:0] ENABLE_EXT_RST     = 8'h00;
  localparam logic [7:0] ENABLE_PERI_RST    = 8'h00;
  localparam logic [7:0] TRIGGER_CTRL_RST   = 8'h00;
  localparam logic [6:0] EXT_PIN_RST        = 7'h7f;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] POWER_CONTROL_MASK = 8'h8f;
  localparam logic [7:0] PRIO_LOW_MASK      = 8'h7f;
  localparam logic [7:0] PRIO_HIGH_MASK     = 8'h3f;
  localparam logic [7:0] TRIGGER_CTRL_MASK  = 8'h0f;
  localparam logic [7:0] ENABLE_PERI_MASK   = 8'h0f;

  // Field positions
  localparam int PC_IDLE_BIT     = 0;
  localparam int PC_STOP_BIT     = 1;
  localparam int PC_BAUD_BIT     = 7;
  localparam int PL_WATCHDOG_BIT = 6;
  localparam int GLOBAL_EN_BIT   = 7;

  // Polling positions of the sources, first position is polled first
  localparam src_idx_t P_EXT0  = 4'h0;
  localparam src_idx_t P_SER_B = 4'h1;
  localparam src_idx_t P_TIM_A = 4'h2;
  localparam src_idx_t P_EXT2  = 4'h3;
  localparam src_idx_t P_EXT1  = 4'h4;
  localparam src_idx_t P_EXT3  = 4'h5;
  localparam src_idx_t P_TIM_B = 4'h6;
  localparam src_idx_t P_EXT4  = 4'h7;
  localparam src_idx_t P_SER_A = 4'h8;
  localparam src_idx_t P_EXT5  = 4'h9;
  localparam src_idx_t P_EXT6  = 4'ha;

  // Priority group and vector of each polling position
  localparam logic [2:0] SRC_GROUP [NUM_SRC] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5};
  localparam logic [15:0] SRC_VECTOR [NUM_SRC] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b, 16'h0013,
                                                   16'h0053, 16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h006b};
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Request presented to the CPU core
  typedef struct packed {
    logic       valid;
    logic [1:0] level;
    src_idx_t   source;
  } cpu_req_s;

endpackage

// ===== cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model
  import irq_prio_pkg::*;
#(
  parameter int ACK_DELAY    = 2,
  parameter int RETURN_DELAY = 60
) (
  // Clock and reset
  input  wire logic     mclk_i,
  input  wire logic     rstn_i,
  // Request side of the controller
  input  wire cpu_req_s cpu_req_i,
  output logic          cpu_ack_o,
  output logic          cpu_reti_o
);
  int wait_cnt;
  int run_cnt;
  int depth;

  // Take a request once it has stood a while; return handlers newest first
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_ack_o  <= 1'b0;
      cpu_reti_o <= 1'b0;
      wait_cnt   <= 0;
      run_cnt    <= 0;
      depth      <= 0;
    end else begin
      cpu_ack_o  <= 1'b0;
      cpu_reti_o <= 1'b0;
      wait_cnt   <= cpu_req_i.valid ? wait_cnt + 1 : 0;
      run_cnt    <= run_cnt + 1;
      // Guard on our own ack: the request still stands in the cycle it is taken
      if (cpu_req_i.valid && wait_cnt >= ACK_DELAY && !cpu_ack_o) begin
        cpu_ack_o <= 1'b1;
        wait_cnt  <= 0;
        depth     <= depth + 1;
        run_cnt   <= 0;
      end else if (depth > 0 && run_cnt >= RETURN_DELAY) begin
        cpu_reti_o <= 1'b1;
        depth      <= depth - 1;
        run_cnt    <= 0;
      end
    end
  end
endmodule // cpu_core_model

// ===== irq_prio_ctrl_checker.sv
`timescale 1ns/100ps
module irq_prio_ctrl_checker
  import irq_prio_pkg::*;
#(
  parameter int VECTOR_WIDTH = 16
) (
  // Everything seen at the controller ports
  input wire logic                    mclk_i,
  input wire logic                    rstn_i,
  input wire logic [7:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              rdata_o,
  input wire logic [6:0]              ext_irq_input_i,
  input wire logic                    timer_a_overflow_i,
  input wire logic                    timer_b_overflow_i,
  input wire logic                    serial_a_rx_flag_i,
  input wire logic                    serial_a_tx_flag_i,
  input wire logic                    serial_b_rx_flag_i,
  input wire logic                    serial_b_tx_flag_i,
  input wire logic                    cpu_ack_i,
  input wire logic                    cpu_reti_i,
  input wire cpu_req_s                cpu_req_o,
  input wire logic [VECTOR_WIDTH-1:0] irq_vector_o,
  input wire logic [3:0]              peri_ack_o,
  input wire logic                    stop_o,
  input wire logic                    idle_o,
  input wire logic                    baud_double_o,
  input wire logic                    watchdog_start_o,
  input wire logic                    wake_o,
  input wire logic                    irq_o
);
  // One domain, so clock and reset are given once
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  winner_vector_a: assert property (cpu_req_o.valid |-> irq_vector_o == VECTOR_WIDTH'(SRC_VECTOR[cpu_req_o.source]))
    else $error("vector does not match requesting source");
  idle_vector_a: assert property (!cpu_req_o.valid |-> irq_vector_o == '0)
    else $error("vector shown without a request");
  taken_drop_a: assert property (cpu_ack_i && cpu_req_o.valid |=> !cpu_req_o.valid)
    else $error("request still standing after it was taken");
  high_unused_a: assert property ($past(rd_i && addr_i == PRIO_HIGH_ADDR) |-> rdata_o[7:6] == 2'b00)
    else $error("unused priority bits read as one");
  stop_cause_a: assert property ($rose(stop_o) |-> $past(wr_i && addr_i == POWER_CONTROL_ADDR && wdata_i[PC_STOP_BIT]))
    else $error("stop entered without a write");
  baud_cause_a: assert property ($changed(baud_double_o) |-> $past(wr_i && addr_i == POWER_CONTROL_ADDR))
    else $error("baud doubling changed without a write");
  watchdog_cause_a: assert property ($changed(watchdog_start_o) |-> $past(wr_i && addr_i == PRIO_LOW_ADDR))
    else $error("watchdog start changed without a write");
  wake_pulse_a: assert property (wake_o |-> !stop_o ##1 !wake_o)
    else $error("wake pulse wrong or stop still set");
  peri_pulse_a: assert property (peri_ack_o != 4'h0 |-> $onehot(peri_ack_o) && $past(cpu_ack_i && cpu_req_o.valid) ##1 peri_ack_o == 4'h0)
    else $error("peripheral acknowledge without a taken request");
endmodule // irq_prio_ctrl_checker

bind irq_prio_ctrl irq_prio_ctrl_checker #(.VECTOR_WIDTH(VECTOR_WIDTH)) chk_i (.*);

// ===== irq_prio_ctrl_test.sv
`timescale 1ns/100ps
module irq_prio_ctrl_test;
  import irq_prio_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [6:0]  ext_irq_input_i = 7'h7f;
  logic [5:0]  peri = 6'h00;
  logic [5:0]  peri_set = 6'h00;
  logic [7:0]  rdata_o;
  cpu_req_s    cpu_req_o;
  logic [15:0] irq_vector_o;
  logic [3:0]  peri_ack_o;
  logic        cpu_ack_i, cpu_reti_i, stop_o, idle_o, baud_double_o, watchdog_start_o, wake_o, irq_o;
  logic        woke = 1'b0;
  logic [15:0] taken[$];
  logic [1:0]  lvls[$];
  int          fail_count = 0;
  int          n_checks = 0;
  // Vectors by bench index: ext0..ext6, timer a, timer b, serial a rx, serial b tx, serial a tx, serial b rx
  logic [15:0] vec [13] = '{16'h0003, 16'h0013, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b,
                            16'h000b, 16'h001b, 16'h0023, 16'h0083, 16'h0023, 16'h0083};
  int          ord [11] = '{6, 9, 5, 8, 4, 0, 10, 7, 2, 1, 3};
  logic [1:0]  lvl_exp [11] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};

  always #5 mclk_i = ~mclk_i;

  irq_prio_ctrl uut (.*, .timer_a_overflow_i(peri[0]), .timer_b_overflow_i(peri[1]), .serial_a_rx_flag_i(peri[2]),
                     .serial_a_tx_flag_i(peri[4]), .serial_b_rx_flag_i(peri[5]), .serial_b_tx_flag_i(peri[3]));
  cpu_core_model core (.mclk_i(mclk_i), .rstn_i(rstn_i), .cpu_req_i(cpu_req_o), .cpu_ack_o(cpu_ack_i),
                       .cpu_reti_o(cpu_reti_i));

  // Peripherals hold their flag until told the request was taken; both serial flags share one ack
  always @(posedge mclk_i) begin
    peri <= (peri & ~{peri_ack_o[3:2], peri_ack_o}) | peri_set;
    if (cpu_ack_i === 1'b1 && cpu_req_o.valid === 1'b1) begin
      taken.push_back(irq_vector_o);
      lvls.push_back(cpu_req_o.level);
    end
    if (wake_o === 1'b1) woke <= 1'b1;
  end

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 chk("rdata", {8'h00, exp}, {8'h00, rdata_o});
  endtask

  // Pins pulse low: ext0-3 act on the fall, ext4-6 on the return high
  task automatic fire(int i);
    @(posedge mclk_i);
    if (i < 7) begin
      ext_irq_input_i[i] <= 1'b0;
      repeat (8) @(posedge mclk_i);
      ext_irq_input_i[i] <= 1'b1;
    end else begin
      peri_set[i-7] <= 1'b1;
      @(posedge mclk_i);
      peri_set      <= 6'h00;
    end
  endtask

  task automatic wait_taken(int n);
    int k = 0;
    while (taken.size() < n && k < 2000) begin
      @(posedge mclk_i);
      k++;
    end
    if (taken.size() < n) begin
      fail_count++;
      $display("CHECK FAILED taken count expected %0d seen %0d", n, taken.size());
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cut a hang short well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(POWER_CONTROL_ADDR, 8'h00);
    rd(PRIO_LOW_ADDR, 8'h00);
    rd(PRIO_HIGH_ADDR, 8'h00);
    wr(POWER_CONTROL_ADDR, 8'hff);
    rd(POWER_CONTROL_ADDR, 8'h8f);
    chk("power outputs", 16'h0007, {13'h0, stop_o, idle_o, baud_double_o});
    wr(PRIO_LOW_ADDR, 8'hff);
    rd(PRIO_LOW_ADDR, 8'h7f);
    chk("watchdog start", 16'h0001, {15'h0, watchdog_start_o});
    wr(PRIO_HIGH_ADDR, 8'hff);
    rd(PRIO_HIGH_ADDR, 8'h3f);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(POWER_CONTROL_ADDR, 8'h00);
    wr(PRIO_LOW_ADDR, 8'h00);
    wr(PRIO_HIGH_ADDR, 8'h00);
    wr(TRIGGER_CTRL_ADDR, 8'h03);
    // Flag records while masked, then raises the line once unmasked, then clears
    fire(2);
    repeat (8) @(posedge mclk_i);
    rd(EXT_FLAG_ADDR, 8'h04);
    chk("irq masked", 16'h0000, {15'h0, irq_o});
    wr(ENABLE_EXT_ADDR, 8'h04);
    rd(EXT_FLAG_ADDR, 8'h04);
    chk("irq unmasked", 16'h0001, {15'h0, irq_o});
    wr(EXT_FLAG_ADDR, 8'h04);
    rd(EXT_FLAG_ADDR, 8'h00);
    chk("irq cleared", 16'h0000, {15'h0, irq_o});
    // Every source alone reaches the core with its own vector
    wr(ENABLE_PERI_ADDR, 8'h0f);
    wr(ENABLE_EXT_ADDR, 8'hff);
    for (int i = 0; i < 13; i++) begin
      taken.delete();
      fire(i);
      wait_taken(1);
      chk("single vector", vec[i], taken[0]);
    end
    // All pending at once across four levels: level first, then polling order
    repeat (150) @(posedge mclk_i);
    wr(ENABLE_EXT_ADDR, 8'h7f);
    wr(PRIO_LOW_ADDR, 8'h28);
    wr(PRIO_HIGH_ADDR, 8'h30);
    for (int i = 0; i < 11; i++) fire(i);
    repeat (10) @(posedge mclk_i);
    taken.delete();
    lvls.delete();
    wr(ENABLE_EXT_ADDR, 8'hff);
    wait_taken(11);
    for (int j = 0; j < 11; j++) chk("service order", vec[ord[j]], taken[j]);
    for (int j = 0; j < 11; j++) chk("service level", {14'h0, lvl_exp[j]}, {14'h0, lvls[j]});
    rd(EXT_FLAG_ADDR, 8'h00);
    // Equal level waits for the return, a higher level breaks in
    taken.delete();
    fire(0);
    wait_taken(1);
    fire(1);
    repeat (5) @(posedge mclk_i);
    fire(6);
    wait_taken(3);
    chk("nest first", vec[0], taken[0]);
    chk("nest second", vec[6], taken[1]);
    chk("nest third", vec[1], taken[2]);
    // External input 0 ends stop mode
    repeat (150) @(posedge mclk_i);
    wr(POWER_CONTROL_ADDR, 8'h02);
    rd(POWER_CONTROL_ADDR, 8'h02);
    fire(0);
    repeat (6) @(posedge mclk_i);
    chk("wake seen", 16'h0001, {15'h0, woke});
    rd(POWER_CONTROL_ADDR, 8'h00);
    // Trigger modes: ext0 low level re-arms under a clear, ext1 on the fall only, ext2 on the rise
    wr(ENABLE_EXT_ADDR, 8'h00);
    wr(TRIGGER_CTRL_ADDR, 8'h06);
    @(posedge mclk_i);
    ext_irq_input_i <= 7'h78;
    repeat (10) @(posedge mclk_i);
    rd(EXT_FLAG_ADDR, 8'h03);
    wr(EXT_FLAG_ADDR, 8'h03);
    rd(EXT_FLAG_ADDR, 8'h01);
    @(posedge mclk_i);
    ext_irq_input_i <= 7'h7f;
    repeat (10) @(posedge mclk_i);
    rd(EXT_FLAG_ADDR, 8'h05);
    chk("irq disabled", 16'h0000, {15'h0, irq_o});
    final_report();
  end
endmodule // irq_prio_ctrl_test
